// ### verilog/eee_port_defines.vh
/*
 * Constants for the per-port energy save control register and its
 * indirect access window. Included by the port control and register design files.
 */
`ifndef EEE_PORT_DEFINES_VH
`define EEE_PORT_DEFINES_VH

// Direct byte addresses of the indirect window
`define ADDR_INDIRECT_CTRL      8'h6e
`define ADDR_INDIRECT_OFFSET    8'h6f
`define ADDR_INDIRECT_DATA      8'ha0

// Indirect access control byte fields
`define CTRL_SPACE_MSB          7
`define CTRL_SPACE_LSB          5
`define CTRL_SPACE_ENERGY       3'h1
`define CTRL_READ_BIT           4
`define CTRL_PORT_MSB           3
`define CTRL_PORT_LSB           0
`define PORT_FIRST              4'h1
`define PORT_LAST               4'h3

// Indirect offsets of the control register bytes
`define OFS_CTRL_HIGH           8'h2c
`define OFS_CTRL_LOW            8'h2d

// Field positions in the 16-bit control register
`define BIT_TEN_DISABLE         15
`define BIT_HW_EXCHANGE         7
`define BIT_HW_STATUS           6
`define BIT_TX_STICKY           5
`define BIT_TX_LIVE             4
`define BIT_RX_STICKY           3
`define BIT_RX_LIVE             2
`define BIT_SW_SELECT           1
`define BIT_FAST_ENABLE         0

// Reset values of writable fields
`define RST_TEN_DISABLE         1'b1
`define RST_HW_EXCHANGE         1'b1
`define RST_SW_SELECT           1'b0
`define RST_FAST_ENABLE         1'b0

`endif

// ### verilog/idle_sticky.v
/*
 * One clear-on-read sticky flag for low power idle seen by a PCS.
 * Assumes the live indication is synchronous to the core clock.
 */
`default_nettype none

module idle_sticky (
    input  wire i_core_clk,
    input  wire i_rst_n,
    input  wire i_idle_live,
    input  wire i_clear,
    output reg  o_seen
);

    // Set wins over the read that clears, so no event is lost
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_seen <= 1'b0;
        else if (i_idle_live)
            o_seen <= 1'b1;
        else if (i_clear)
            o_seen <= 1'b0;
    end

endmodule // idle_sticky

`default_nettype wire

// ### verilog/port_energy_ctrl.v
/*
 * Control fields of one port's energy save register: software bits,
 * hardware capability result and the resulting enable outputs.
 * Assumes the negotiation result is a synchronous one-cycle pulse.
 */
`default_nettype none
`include "eee_port_defines.vh"

module port_energy_ctrl (
    input  wire       i_core_clk,
    input  wire       i_rst_n,
    input  wire       i_wr_high,
    input  wire       i_wr_low,
    input  wire [7:0] i_wdata,
    input  wire       i_neg_done,
    input  wire       i_neg_match,
    output reg        o_ten_disable,
    output reg        o_hw_exchange,
    output reg        o_hw_status,
    output reg        o_sw_select,
    output reg        o_fast_enable
);

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_ten_disable <= `RST_TEN_DISABLE;
            o_hw_exchange <= `RST_HW_EXCHANGE;
            o_sw_select   <= `RST_SW_SELECT;
            o_fast_enable <= `RST_FAST_ENABLE;
            o_hw_status   <= 1'b0;
        end
        else
        begin
            if (i_wr_high)
                o_ten_disable <= i_wdata[`BIT_TEN_DISABLE - 8];
            if (i_wr_low)
            begin
                o_hw_exchange <= i_wdata[`BIT_HW_EXCHANGE];
                o_sw_select   <= i_wdata[`BIT_SW_SELECT];
            end
            // Hardware set wins over a same-cycle software write
            if (i_neg_done && o_hw_exchange && i_neg_match)
                o_fast_enable <= 1'b1;
            else if (i_wr_low)
                o_fast_enable <= i_wdata[`BIT_FAST_ENABLE];
            if (i_neg_done && o_hw_exchange)
                o_hw_status <= i_neg_match;
            else if (!o_hw_exchange)
                o_hw_status <= 1'b0;
        end
    end

endmodule // port_energy_ctrl

`default_nettype wire

// ### verilog/eee_port_control_register.v
/*
 * Per-port energy save control and status register for ports 1..3,
 * reached through the indirect control, offset and data byte window.
 * Assumes a simple synchronous byte register port: one-cycle write and
 * read strobes with address; read data is valid the cycle after.
 */
// What this block does
// - Control byte bits 7:5 equal 001 select the energy save space.
// - Control byte bits 3:0 pick the port; only ports 1 to 3 valid.
// - Offset byte selects the register byte, exchanged via the data byte.
// - Upper byte sits at offset 0x2c, lower byte at 0x2d.
// - Bit 15 set disables ten megabit energy save mode; resets to one.
// - Ten megabit energy save only lowers transmit amplitude.
// - Bit 7 set lets hardware exchange capability by next pages; resets one.
// - Matching hardware exchange sets the fast enable bit 0.
// - Bit 7 clear stops hardware exchange; software does it instead.
// - Read-only bit 6 shows fast mode enabled by hardware exchange.
// - Bit 5 latches transmit idle seen since last read; read clears.
// - Bit 4 shows live transmit idle, unlatched.
// - Bit 3 latches receive idle seen since last read; read clears.
// - Bit 2 shows live receive idle, unlatched.
// - Bit 1 set makes software bit 0 govern energy save; resets zero.
// - Bit 1 clear makes hardware negotiation govern energy save.
// - Bit 0 enables fast energy save; read-write, resets zero.
// - Bit 0 written by software or set by hardware exchange.
`default_nettype none
`include "eee_port_defines.vh"

module eee_port_control_register #(
    parameter NPORTS = 3
) (
    input  wire              i_core_clk,
    input  wire              i_rst_n,
    input  wire              i_wr,
    input  wire              i_rd,
    input  wire [7:0]        i_addr,
    input  wire [7:0]        i_wdata,
    input  wire [NPORTS-1:0] i_tx_idle,
    input  wire [NPORTS-1:0] i_rx_idle,
    input  wire [NPORTS-1:0] i_neg_done,
    input  wire [NPORTS-1:0] i_neg_match,
    output reg  [7:0]        o_rdata,
    output reg  [NPORTS-1:0] o_fast_energy_on,
    output reg  [NPORTS-1:0] o_ten_amplitude_low
);

    reg  [7:0]        ctrl_byte;
    reg  [7:0]        offset_byte;
    reg  [7:0]        held_byte;
    wire [NPORTS-1:0] ten_disable;
    wire [NPORTS-1:0] hw_exchange;
    wire [NPORTS-1:0] hw_status;
    wire [NPORTS-1:0] sw_select;
    wire [NPORTS-1:0] fast_enable;
    wire [NPORTS-1:0] tx_seen;
    wire [NPORTS-1:0] rx_seen;
    wire [NPORTS-1:0] clr_sticky;
    wire [NPORTS-1:0] wr_high;
    wire [NPORTS-1:0] wr_low;

    wire space_ok = (ctrl_byte[`CTRL_SPACE_MSB:`CTRL_SPACE_LSB]
                    == `CTRL_SPACE_ENERGY);
    wire [3:0] port_sel = ctrl_byte[`CTRL_PORT_MSB:`CTRL_PORT_LSB];
    wire port_ok = (port_sel >= `PORT_FIRST) && (port_sel <= `PORT_LAST);
    wire is_read = ctrl_byte[`CTRL_READ_BIT];
    wire data_wr = i_wr && (i_addr == `ADDR_INDIRECT_DATA) && space_ok
                   && port_ok && !is_read;
    // Writing the offset in read mode triggers the fetch
    wire fetch = i_wr && (i_addr == `ADDR_INDIRECT_OFFSET) && space_ok
                 && is_read;

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_byte   <= 8'h00;
            offset_byte <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == `ADDR_INDIRECT_CTRL)
                ctrl_byte <= i_wdata;
            if (i_addr == `ADDR_INDIRECT_OFFSET)
                offset_byte <= i_wdata;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPORTS; p = p + 1)
        begin : g_port
            wire hit = port_ok && (port_sel == p + 1);
            assign wr_high[p] = data_wr && hit && (offset_byte == `OFS_CTRL_HIGH);
            assign wr_low[p]  = data_wr && hit && (offset_byte == `OFS_CTRL_LOW);
            // Sticky bits sit in the low byte; only its fetch clears them
            assign clr_sticky[p] = fetch && port_ok && (port_sel == p + 1)
                                   && (i_wdata == `OFS_CTRL_LOW);

            port_energy_ctrl u_ctrl (
                .i_core_clk    (i_core_clk),
                .i_rst_n       (i_rst_n),
                .i_wr_high     (wr_high[p]),
                .i_wr_low      (wr_low[p]),
                .i_wdata       (i_wdata),
                .i_neg_done    (i_neg_done[p]),
                .i_neg_match   (i_neg_match[p]),
                .o_ten_disable (ten_disable[p]),
                .o_hw_exchange (hw_exchange[p]),
                .o_hw_status   (hw_status[p]),
                .o_sw_select   (sw_select[p]),
                .o_fast_enable (fast_enable[p])
            );

            idle_sticky u_tx (
                .i_core_clk  (i_core_clk),
                .i_rst_n     (i_rst_n),
                .i_idle_live (i_tx_idle[p]),
                .i_clear     (clr_sticky[p]),
                .o_seen      (tx_seen[p])
            );

            idle_sticky u_rx (
                .i_core_clk  (i_core_clk),
                .i_rst_n     (i_rst_n),
                .i_idle_live (i_rx_idle[p]),
                .i_clear     (clr_sticky[p]),
                .o_seen      (rx_seen[p])
            );

            always @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    o_fast_energy_on[p]    <= 1'b0;
                    o_ten_amplitude_low[p] <= 1'b0;
                end
                else
                begin
                    // Software mode follows bit 0, else the negotiated result
                    o_fast_energy_on[p] <= sw_select[p] ? fast_enable[p]
                                                        : hw_status[p];
                    // Only amplitude is lowered; no other low power state
                    o_ten_amplitude_low[p] <= !ten_disable[p];
                end
            end
        end
    endgenerate

    // Byte image of the selected port, computed at fetch time
    reg [7:0] next_held;
    integer   k;
    always @*
    begin
        next_held = 8'h00;
        for (k = 0; k < NPORTS; k = k + 1)
        begin
            if (port_sel == k + 1)
            begin
                if (i_wdata == `OFS_CTRL_HIGH)
                    next_held = {ten_disable[k], 7'h00};
                else if (i_wdata == `OFS_CTRL_LOW)
                    next_held = {hw_exchange[k], hw_status[k], tx_seen[k],
                                 i_tx_idle[k], rx_seen[k], i_rx_idle[k],
                                 sw_select[k], fast_enable[k]};
            end
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            held_byte <= 8'h00;
            o_rdata   <= 8'h00;
        end
        else
        begin
            if (fetch)
                held_byte <= next_held;
            if (i_rd)
            begin
                case (i_addr)
                    `ADDR_INDIRECT_CTRL:   o_rdata <= ctrl_byte;
                    `ADDR_INDIRECT_OFFSET: o_rdata <= offset_byte;
                    `ADDR_INDIRECT_DATA:   o_rdata <= held_byte;
                    default:               o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // eee_port_control_register

`default_nettype wire

// ### tb/eee_port_props.sv
/* Assertions on the energy save register window.
   Bound to the register block; sees its ports only. */
`default_nettype none
module eee_port_props #(parameter NPORTS = 3) (
    input wire logic              i_core_clk,
    input wire logic              i_rst_n,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [7:0]        i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic [NPORTS-1:0] i_tx_idle,
    input wire logic [NPORTS-1:0] i_rx_idle,
    input wire logic [NPORTS-1:0] i_neg_done,
    input wire logic [7:0]        o_rdata,
    input wire logic [NPORTS-1:0] o_fast_energy_on,
    input wire logic [NPORTS-1:0] o_ten_amplitude_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [1:0] live;
    logic       lo;
    wire        port_ok = ctrl[3:0] >= 4'h1 && ctrl[3:0] <= 4'h3;
    wire  [1:0] idx = ctrl[1:0] - 2'h1;
    wire        rd_data = i_rd && i_addr == 8'ha0;
    wire        wr_data = i_wr && i_addr == 8'ha0;
    wire        cause = wr_data || |i_neg_done;
    wire        fetch = i_wr && i_addr == 8'h6f && ctrl[7:4] == 4'h3;
    // Mirror of the last fetch, so each data read can be judged
    always_ff @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
        begin
            ctrl <= 8'h00;
            mask <= 8'h00;
            live <= 2'h0;
            lo <= 1'b0;
        end
        else
        begin
            if (i_wr && i_addr == 8'h6e)
                ctrl <= i_wdata;
            if (fetch)
            begin
                lo <= port_ok && i_wdata == 8'h2d;
                live <= {i_tx_idle[idx], i_rx_idle[idx]};
                mask <= (!port_ok || i_wdata[7:1] != 7'h16) ? 8'hff
                      : (i_wdata[0] ? 8'h00 : 8'h7f);
            end
        end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    read_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (i_rd && i_addr != 8'h6e && i_addr != 8'h6f
        && i_addr != 8'ha0 |=> o_rdata == 8'h00) else $error("unmapped read");
    bad_fetch_a: assert property (rd_data && mask == 8'hff |=> o_rdata == 8'h00)
        else $error("bad fetch data");
    reserved_zero_a: assert property (rd_data && mask == 8'h7f |=> o_rdata[6:0] == 7'h00)
        else $error("reserved bits set");
    tx_live_a: assert property (rd_data && lo |=> o_rdata[4] == $past(live[1]))
        else $error("tx live bit");
    rx_live_a: assert property (rd_data && lo |=> o_rdata[2] == $past(live[0]))
        else $error("rx live bit");
    ten_cause_a: assert property ($changed(o_ten_amplitude_low)
        |-> $past(wr_data) || $past(wr_data, 2)) else $error("ten mode moved");
    fast_cause_a: assert property ($changed(o_fast_energy_on)
        |-> $past(cause) || $past(cause, 2)) else $error("fast enable moved");
endmodule // eee_port_props
bind eee_port_control_register eee_port_props #(.NPORTS(NPORTS)) eee_port_props_i (.*);
`default_nettype wire

// ### tb/eee_port_control_register_test.sv
/* Bench for the energy save register window: byte access tasks and
   expected values. Assumes the props checker is bound to the block. */
`default_nettype none
module eee_port_control_register_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_core_clk = 0;
    logic       i_rst_n = 0;
    logic       i_wr = 0;
    logic       i_rd = 0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [2:0] i_tx_idle = 3'h0;
    logic [2:0] i_rx_idle = 3'h0;
    logic [2:0] i_neg_done = 3'h0;
    logic [2:0] i_neg_match = 3'h0;
    logic [7:0] o_rdata;
    logic [7:0] d;
    logic [2:0] o_fast_energy_on;
    logic [2:0] o_ten_amplitude_low;
    int         n_errors = 0;
    int         checked = 0;
    eee_port_control_register #(.NPORTS(3)) eee_port_control_register_i (.*);
    initial forever #12.5 i_core_clk = ~i_core_clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cyc(1);
        i_wr = 1;
        i_addr = a;
        i_wdata = v;
        cyc(1);
        i_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        cyc(1);
        i_rd = 1;
        i_addr = a;
        cyc(1);
        i_rd = 0;
        d = o_rdata;
    endtask
    // Full indirect sequence: control, offset, then data
    task automatic acc(input logic [3:0] p, input logic [7:0] o, input logic [7:0] v, input bit w);
        wr(8'h6e, {3'h1, ~w, p});
        wr(8'h6f, o);
        if (w)
            wr(8'ha0, v);
        else
            rd(8'ha0);
    endtask
    task automatic neg(input logic [2:0] m, input logic [2:0] ok);
        cyc(1);
        i_neg_done = m;
        i_neg_match = ok;
        cyc(1);
        i_neg_done = 3'h0;
        cyc(2);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        i_rst_n = 1;
        for (int p = 1; p <= 3; p++)
        begin
            acc(p[3:0], 8'h2c, 8'h00, 0);
            chk(d, 8'h80);
            acc(p[3:0], 8'h2d, 8'h00, 0);
            chk(d, 8'h80);
        end
        chk({5'h0, o_ten_amplitude_low}, 8'h00);
        $display("reset test done");
        acc(4'h2, 8'h2c, 8'hff, 1);
        acc(4'h2, 8'h2c, 8'h00, 0);
        chk(d, 8'h80);
        acc(4'h2, 8'h2c, 8'h00, 1);
        acc(4'h2, 8'h2c, 8'h00, 0);
        chk(d, 8'h00);
        chk({5'h0, o_ten_amplitude_low}, 8'h02);
        acc(4'h1, 8'h2d, 8'h3f, 1);
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h03);
        chk({5'h0, o_fast_energy_on}, 8'h01);
        acc(4'h1, 8'h2d, 8'h02, 1);
        cyc(2);
        chk({5'h0, o_fast_energy_on}, 8'h00);
        $display("write test done");
        neg(3'h4, 3'h4);
        acc(4'h3, 8'h2d, 8'h00, 0);
        chk(d, 8'hc1);
        chk({5'h0, o_fast_energy_on}, 8'h04);
        neg(3'h4, 3'h0);
        acc(4'h3, 8'h2d, 8'h00, 0);
        chk(d, 8'h81);
        chk({5'h0, o_fast_energy_on}, 8'h00);
        acc(4'h2, 8'h2d, 8'h00, 1);
        neg(3'h2, 3'h2);
        acc(4'h2, 8'h2d, 8'h00, 0);
        chk(d, 8'h00);
        $display("exchange test done");
        i_tx_idle = 3'h1;
        cyc(2);
        i_tx_idle = 3'h0;
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h22);
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h02);
        i_tx_idle = 3'h1;
        i_rx_idle = 3'h1;
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h3e);
        i_tx_idle = 3'h0;
        i_rx_idle = 3'h0;
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h2a);
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h02);
        $display("idle test done");
        acc(4'h0, 8'h2d, 8'h00, 0);
        chk(d, 8'h00);
        acc(4'h4, 8'h2d, 8'h00, 0);
        chk(d, 8'h00);
        acc(4'h1, 8'h2e, 8'h00, 0);
        chk(d, 8'h00);
        wr(8'h6e, 8'h42);
        wr(8'h6f, 8'h2d);
        wr(8'ha0, 8'h03);
        acc(4'h2, 8'h2d, 8'h00, 0);
        chk(d, 8'h00);
        wr(8'h6e, 8'h31);
        wr(8'h6f, 8'h2d);
        wr(8'ha0, 8'h03);
        rd(8'ha0);
        chk(d, 8'h02);
        // The data write in read mode must have left port 1 alone
        acc(4'h1, 8'h2d, 8'h00, 0);
        chk(d, 8'h02);
        rd(8'h6e);
        chk(d, 8'h31);
        rd(8'h6f);
        chk(d, 8'h2d);
        rd(8'h55);
        chk(d, 8'h00);
        $display("refusal test done");
        // Mid-run reset must bring the fields back to their reset values
        i_rst_n = 0;
        cyc(2);
        i_rst_n = 1;
        acc(4'h2, 8'h2c, 8'h00, 0);
        chk(d, 8'h80);
        chk({5'h0, o_ten_amplitude_low}, 8'h00);
        acc(4'h3, 8'h2d, 8'h00, 0);
        chk(d, 8'h80);
        chk({5'h0, o_fast_energy_on}, 8'h00);
        $display("second reset test done");
        test_done;
    end
endmodule // eee_port_control_register_test
`default_nettype wire
